/* File: lane_mapper_pkg.sv */
// Purpose: Shared constants and types for the pixel-to-lane mapper.
// Assumes: A 28-bit pixel word and four lanes of seven slots each.
// Notes:   Slot tables give payload bit numbers in transmit order.
package lane_mapper_pkg;

  // Word and lane geometry.
  localparam int WORD_W  = 28;
  localparam int LANES   = 4;
  localparam int SLOTS   = 7;
  localparam int COLOURS = 3;

  // Field positions inside the captured pixel word.
  localparam int W_RED   = 0;
  localparam int W_GREEN = 8;
  localparam int W_BLUE  = 16;
  localparam int W_HS    = 24;
  localparam int W_VS    = 25;
  localparam int W_DE    = 26;
  localparam int W_SPARE = 27;

  // Payload positions of the sync and enable bits.
  localparam int D_HS = 24;
  localparam int D_VS = 25;
  localparam int D_DE = 26;

  // Slot counter limits and clock lane shape.
  localparam logic [2:0] LAST_SLOT     = 3'h6;
  localparam logic [2:0] CLK_FALL_SLOT = 3'h4;
  localparam logic [2:0] SLOT_RESET    = 3'h0;

  typedef logic [4:0] idx_t;

  // Payload bit carried in each slot of each lane, slot 0 sent first.
  localparam idx_t LANE_BIT [LANES][SLOTS] = '{
    '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07},
    '{5'h08, 5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h12},
    '{5'h13, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A},
    '{5'h1B, 5'h05, 5'h0A, 5'h0B, 5'h10, 5'h11, 5'h17}
  };

  // Payload bits owned by each colour: six main slots, then two on lane 3.
  localparam idx_t COLOUR_POS [COLOURS][8] = '{
    '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h1B, 5'h05},
    '{5'h07, 5'h08, 5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0A, 5'h0B},
    '{5'h0F, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h10, 5'h11}
  };

  // Colour formats selected by the mode pins.
  typedef enum logic [2:0] {
    MODE_FMT1   = 3'h0,
    MODE_FMT2   = 3'h1,
    MODE_FMT3   = 3'h2,
    MODE_6BIT   = 3'h3,
    MODE_4B_NL  = 3'h4,
    MODE_4B_LIN = 3'h5
  } colour_mode_t;

  typedef enum logic [0:0] {
    PH_OFF = 1'h0,
    PH_RUN = 1'h1
  } phase_t;

endpackage : lane_mapper_pkg

/* File: lane_xfer_if.sv */
// Purpose: Carries one captured pixel word from the pixel clock domain.
// Assumes: Toggle request and acknowledge, word stable while they differ.
// Notes:   The serial side must sample req through two flip-flops.
`timescale 1ns/1ps
interface lane_xfer_if;
  import lane_mapper_pkg::*;
  logic              req;
  logic              ack;
  logic [WORD_W-1:0] word;

  modport capture (output req, output word, input ack);
  modport serial  (input req, input word, output ack);
endinterface : lane_xfer_if

/* File: pixel_capture.sv */
// Purpose: Captures the pixel word on the selected edge of the pixel clock.
// Assumes: rst_n is low whenever power-down is asserted.
// Notes:   A new word is offered only once the last one was acknowledged.
`timescale 1ns/1ps
module pixel_capture
  import lane_mapper_pkg::*;
(
  input  wire logic              pixel_clock_in,
  input  wire logic              rst_n,
  input  wire logic              capture_edge_select,
  input  wire logic [WORD_W-1:0] pix_word,
  lane_xfer_if.capture           xfer
);

  typedef struct packed {
    logic              sel_meta;
    logic              sel_sync;
    logic              ack_meta;
    logic              ack_sync;
    logic              req;
    logic [WORD_W-1:0] hold;
  } cap_state_t;

  cap_state_t        r;
  cap_state_t        n;
  logic [WORD_W-1:0] fall_word_r;
  logic              px_rst_meta_r;
  logic              px_rst_n_r;

  // Reset asserts at once but is released on a pixel edge, so no flop
  // sees its release near its own clock edge; a stopped clock holds it.
  always_ff @(posedge pixel_clock_in or negedge rst_n) begin
    if (!rst_n) begin
      px_rst_meta_r <= 1'h0;
      px_rst_n_r    <= 1'h0;
    end else begin
      px_rst_meta_r <= 1'h1;
      px_rst_n_r    <= px_rst_meta_r;
    end
  end

  // Falling-edge copy, used only when the falling edge is selected.
  always_ff @(negedge pixel_clock_in or negedge px_rst_n_r) begin
    if (!px_rst_n_r) begin
      fall_word_r <= '0;
    end else begin
      fall_word_r <= pix_word;
    end
  end

  // word load
  // A falling-edge capture is handed on at the next rising edge.
  always_comb begin
    n          = r;
    n.sel_meta = capture_edge_select;
    n.sel_sync = r.sel_meta;
    n.ack_meta = xfer.ack;
    n.ack_sync = r.ack_meta;
    if (r.req == r.ack_sync) begin
      n.hold = r.sel_sync ? pix_word : fall_word_r;
      n.req  = ~r.req;
    end
  end

  // Power-down clears the capture state through rst_n.
  always_ff @(posedge pixel_clock_in or negedge px_rst_n_r) begin
    if (!px_rst_n_r) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign xfer.req  = r.req;
  assign xfer.word = r.hold;

  // Rising-edge selection must take the pins as seen at that edge.
  property p_rise_capture;
    @(posedge pixel_clock_in) disable iff (!px_rst_n_r)
      (r.req == r.ack_sync && r.sel_sync) |=> r.hold == $past(pix_word);
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("Rising-edge capture did not take the pixel pins.");

endmodule : pixel_capture

/* File: parallel_pixel_to_serial_lane_mapper.sv */
// Purpose: Maps a parallel pixel word onto four serial lanes and a clock lane.
// Assumes: clk runs at 40 MHz; the pixel clock is unrelated in phase.
// Notes:   One word is sent per seven clk cycles; newer words overwrite.
//
// What this block does
// - Capture 24 colour bits, syncs, enable, spare.
// - Capture edge chosen by edge-select pin.
// - Load all 28 payload bits before sending.
// - Fixed payload bit grouping onto four lanes.
// - Syncs and enable sit in D24-D26.
// - Formats 1 and 2 split colour across lanes.
// - Format 3 and 6-bit drive lane 3 low.
// - Power-down stops clocking and disables drivers.
// - Power-down clears all state but the clk-domain input and reset synchronisers.
`timescale 1ns/1ps
module parallel_pixel_to_serial_lane_mapper
  import lane_mapper_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       pixel_clock_in,
  input  wire logic       capture_edge_select,
  input  wire logic       power_down_n,
  input  wire logic [2:0] colour_mode,
  input  wire logic [7:0] red,
  input  wire logic [7:0] green,
  input  wire logic [7:0] blue,
  input  wire logic       line_sync,
  input  wire logic       frame_sync,
  input  wire logic       data_enable,
  input  wire logic       spare,
  output logic            serial_lane_0,
  output logic            serial_lane_1,
  output logic            serial_lane_2,
  output logic            serial_lane_3,
  output logic            forwarded_clock_lane,
  output logic            lane_drive_en
);

  typedef struct packed {
    logic                         pdn_meta;
    logic                         pdn_sync;
    logic [2:0]                   mode_meta;
    logic [2:0]                   mode_sync;
    logic                         req_meta;
    logic                         req_sync;
    logic                         ack;
    logic [WORD_W-1:0]            word;
    logic [LANES-1:0][SLOTS-1:0]  sh;
    logic [2:0]                   cnt;
    phase_t                       phase;
    logic                         drv_en;
    logic                         clk_lane;
  } ser_state_t;

  ser_state_t                  r;
  ser_state_t                  n;
  logic                        rst_meta_r;
  logic                        rst_n_sync;
  logic [WORD_W-1:0]           payload;
  logic [LANES-1:0][SLOTS-1:0] lane_load;
  logic [WORD_W-1:0]           pix_word;

  lane_xfer_if xfer ();

  // Reset is asserted at once and released two clk edges later.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'h0;
      rst_n_sync <= 1'h0;
    end else begin
      rst_meta_r <= 1'h1;
      rst_n_sync <= rst_meta_r;
    end
  end

  assign pix_word = {spare, data_enable, frame_sync, line_sync,
                     blue, green, red};

  // capture side cleared
  // Power-down resets the pixel domain directly, since its clock may stop.
  pixel_capture u_capture (
    .pixel_clock_in      (pixel_clock_in),
    .rst_n               (rst_n_sync & power_down_n),
    .capture_edge_select (capture_edge_select),
    .pix_word            (pix_word),
    .xfer                (xfer.capture)
  );

  // Returns {lane-3 high, lane-3 low, six main slots} for one colour.
  function automatic logic [7:0] colour_slots(logic [2:0] mode,
                                              logic [7:0] c);
    logic [7:0] s;
    s = 8'h00;
    case (mode)
      MODE_FMT1:   s = {c[7], c[6], c[5:0]};
      MODE_FMT2:   s = {c[1], c[0], c[7:2]};
      MODE_FMT3:   s = {2'h0, c[7:2]};
      MODE_6BIT:   s = {2'h0, c[5:0]};
      MODE_4B_NL:  s = {2'h0, c[3:0], c[3], c[2]};
      MODE_4B_LIN: s = {2'h0, c[3:0], 2'h1};
      default:     s = {c[7], c[6], c[5:0]};
    endcase
    return s;
  endfunction : colour_slots

  // sync bit placement
  // Unlisted payload bits, D23 among them, stay low in every format.
  always_comb begin
    logic [7:0] cs;
    logic [7:0] cval;
    cs   = 8'h00;
    cval = 8'h00;
    payload         = '0;
    payload[D_HS]   = r.word[W_HS];
    payload[D_VS]   = r.word[W_VS];
    payload[D_DE]   = r.word[W_DE];
    for (int c = 0; c < COLOURS; c++) begin
      cval = r.word[W_RED + 8*c +: 8];
      cs   = colour_slots(r.mode_sync, cval);
      for (int b = 0; b < 8; b++) begin
        payload[COLOUR_POS[c][b]] = cs[b];
      end
    end
  end

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      assign lane_load[i][s] = payload[LANE_BIT[i][s]];
    end
  end

  // Next-state logic for the clk domain.
  always_comb begin
    n           = r;
    n.pdn_meta  = power_down_n;
    n.pdn_sync  = r.pdn_meta;
    n.mode_meta = colour_mode;
    n.mode_sync = r.mode_meta;
    n.req_meta  = xfer.req;
    n.req_sync  = r.req_meta;
    if (!r.pdn_sync) begin
      n.phase    = PH_OFF;
      n.drv_en   = 1'h0;
      n.clk_lane = 1'h0;
      n.ack      = 1'h0;
      n.word     = '0;
      n.sh       = '0;
      n.cnt      = SLOT_RESET;
    end else begin
      n.phase  = PH_RUN;
      n.drv_en = 1'h1;
      if (r.req_sync != r.ack) begin
        n.word = xfer.word;
        n.ack  = r.req_sync;
      end
      if (r.cnt == LAST_SLOT || r.phase == PH_OFF) begin
        n.cnt = SLOT_RESET;
        n.sh  = lane_load;
      end else begin
        n.cnt = r.cnt + 3'h1;
        for (int i = 0; i < LANES; i++) begin
          n.sh[i] = {1'h0, r.sh[i][SLOTS-1:1]};
        end
      end
      n.clk_lane = (n.cnt < CLK_FALL_SLOT);
    end
  end

  // All clk-domain state but the reset synchroniser is one register.
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign xfer.ack             = r.ack;
  assign serial_lane_0        = r.sh[0][0];
  assign serial_lane_1        = r.sh[1][0];
  assign serial_lane_2        = r.sh[2][0];
  assign serial_lane_3        = r.sh[3][0];
  assign forwarded_clock_lane = r.clk_lane;
  assign lane_drive_en        = r.drv_en;

  // Checks on the clk domain.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_sync);

  property p_pdn_drivers_off;
    !r.pdn_sync |=> !lane_drive_en && r.phase == PH_OFF;
  endproperty
  a_pdn_drivers_off: assert property (p_pdn_drivers_off)
    else $error("Drivers stayed on during power-down.");

  property p_pdn_clears;
    !r.pdn_sync |=> r.sh == '0 && r.word == '0 && r.cnt == SLOT_RESET;
  endproperty
  a_pdn_clears: assert property (p_pdn_clears)
    else $error("Power-down left internal state set.");

  property p_slot_wrap;
    disable iff (!rst_n_sync || !r.pdn_sync)
    (r.pdn_sync && r.phase == PH_RUN && r.cnt == LAST_SLOT)
      |=> r.cnt == SLOT_RESET ##1 r.cnt == 3'h1;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap)
    else $error("Slot counter did not wrap after seven slots.");

  property p_word_taken;
    (r.pdn_sync && r.req_sync != r.ack)
      |=> r.word == $past(xfer.word) && r.ack == $past(r.req_sync);
  endproperty
  a_word_taken: assert property (p_word_taken)
    else $error("Offered pixel word was not taken whole.");

  property p_sync_slots;
    (r.pdn_sync && r.cnt == LAST_SLOT)
      |=> r.sh[2][6:4] == $past(r.word[W_DE:W_HS]);
  endproperty
  a_sync_slots: assert property (p_sync_slots)
    else $error("Sync or enable bits not in their lane slots.");

  property p_lane3_low;
    (r.pdn_sync && r.cnt == LAST_SLOT && r.mode_sync == MODE_FMT3)
      |=> r.sh[3] == '0 ##1 !serial_lane_3;
  endproperty
  a_lane3_low: assert property (p_lane3_low)
    else $error("Lane 3 not low in format 3.");

  property p_six_bit_red;
    (r.pdn_sync && r.cnt == LAST_SLOT && r.mode_sync == MODE_6BIT)
      |=> r.sh[0][5:0] == $past(r.word[W_RED +: 6]);
  endproperty
  a_six_bit_red: assert property (p_six_bit_red)
    else $error("Six-bit red not on lane 0.");

  property p_linear_const;
    (r.pdn_sync && r.cnt == LAST_SLOT && r.mode_sync == MODE_4B_LIN)
      |=> r.sh[0][1:0] == 2'h1 && r.sh[1][6:5] == 2'h1
          && r.sh[0][6] && !r.sh[1][0];
  endproperty
  a_linear_const: assert property (p_linear_const)
    else $error("Linear four-bit constants misplaced.");

  property p_fmt1_lane3;
    (r.pdn_sync && r.cnt == LAST_SLOT && r.mode_sync == MODE_FMT1)
      |=> r.sh[3][1:0] == {$past(r.word[W_RED+7]), $past(r.word[W_RED+6])};
  endproperty
  a_fmt1_lane3: assert property (p_fmt1_lane3)
    else $error("Format 1 red high bits not on lane 3.");

  // A power-down cuts the frame short, so it ends this check as well.
  property p_clock_lane;
    disable iff (!rst_n_sync || !r.pdn_sync)
    (r.pdn_sync && r.phase == PH_RUN && r.cnt == LAST_SLOT)
      |=> forwarded_clock_lane [*4] ##1 !forwarded_clock_lane [*3];
  endproperty
  a_clock_lane: assert property (p_clock_lane)
    else $error("Clock lane not aligned with the slot frame.");

  // Slot contents per format, checked on every frame load that follows LAST_SLOT; drive enable checked in every powered cycle.
  property p_fmt2_lane3;
    (r.pdn_sync && r.cnt == LAST_SLOT && r.mode_sync == MODE_FMT2)
      |=> r.sh[3][1:0] == {$past(r.word[W_RED+1]), $past(r.word[W_RED])};
  endproperty
  a_fmt2_lane3: assert property (p_fmt2_lane3)
    else $error("Format 2 red low bits not on lane 3.");

  property p_reserved_low;
    (r.pdn_sync && r.cnt == LAST_SLOT) |=> !r.sh[3][SLOTS-1];
  endproperty
  a_reserved_low: assert property (p_reserved_low)
    else $error("Reserved payload bit was not driven low.");

  property p_lane0_group;
    (r.pdn_sync && r.cnt == LAST_SLOT && r.mode_sync == MODE_FMT1)
      |=> r.sh[0] == {$past(r.word[W_GREEN]), $past(r.word[W_RED +: 6])};
  endproperty
  a_lane0_group: assert property (p_lane0_group)
    else $error("Lane 0 slots do not hold their payload bits.");

  property p_nonlinear_red;
    (r.pdn_sync && r.cnt == LAST_SLOT && r.mode_sync == MODE_4B_NL)
      |=> r.sh[0][5:0] == {$past(r.word[W_RED+3:W_RED]),
                           $past(r.word[W_RED+3:W_RED+2])};
  endproperty
  a_nonlinear_red: assert property (p_nonlinear_red)
    else $error("Non-linear four-bit red slots misplaced.");

  property p_drive_on;
    r.pdn_sync |=> lane_drive_en && r.phase == PH_RUN;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("Lane drivers not enabled while powered.");

endmodule : parallel_pixel_to_serial_lane_mapper

/* File: pixel_source.sv */
// Purpose: Graphics processor model driving the parallel pixel pins.
// Assumes: Pixel clock of 64 ns, stopped low while run is low.
// Notes:   Pins show word_hi in the high phase and word_lo in the low one.
`timescale 1ns/1ps
module pixel_source
  import lane_mapper_pkg::*;
(
  input  wire logic              run,
  input  wire logic [WORD_W-1:0] word_hi,
  input  wire logic [WORD_W-1:0] word_lo,
  output logic                   pixel_clock_in,
  output logic [7:0]             red,
  output logic [7:0]             green,
  output logic [7:0]             blue,
  output logic                   line_sync,
  output logic                   frame_sync,
  output logic                   data_enable,
  output logic                   spare
);
  logic [WORD_W-1:0] pins;

  // The clock finishes its high phase before standing still, so no runt.
  initial begin
    pixel_clock_in = 1'b0;
    #7;
    forever begin
      #32;
      if (run || pixel_clock_in) pixel_clock_in = ~pixel_clock_in;
    end
  end

  // Data moves 2 ns after each edge, so it holds past either capture edge.
  always @(pixel_clock_in or word_hi or word_lo) begin
    pins <= #2 (pixel_clock_in ? word_hi : word_lo);
  end

  // Word layout, colour bit 0 least significant.
  assign {spare, data_enable, frame_sync, line_sync, blue, green, red} = pins;
endmodule : pixel_source

/* File: tb_parallel_pixel_to_serial_lane_mapper.sv */
// Purpose: Self-checking bench for the pixel-to-lane mapper.
// Assumes: Frames start where the clock lane rises; seven slots each.
// Notes:   Waits allow the two-domain handoff before frames are judged.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_parallel_pixel_to_serial_lane_mapper;
  import lane_mapper_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        pixel_clock_in;
  logic        capture_edge_select;
  logic        power_down_n;
  logic [2:0]  colour_mode;
  logic [7:0]  red;
  logic [7:0]  green;
  logic [7:0]  blue;
  logic        line_sync;
  logic        frame_sync;
  logic        data_enable;
  logic        spare;
  logic        serial_lane_0;
  logic        serial_lane_1;
  logic        serial_lane_2;
  logic        serial_lane_3;
  logic        forwarded_clock_lane;
  logic        lane_drive_en;
  logic        run;
  logic [27:0] word_hi;
  logic [27:0] word_lo;
  int          bad_count;
  int          total_checks;

  parallel_pixel_to_serial_lane_mapper i_dut (.clk(clk), .arst_n(arst_n),
    .pixel_clock_in(pixel_clock_in), .capture_edge_select(capture_edge_select),
    .power_down_n(power_down_n), .colour_mode(colour_mode), .red(red),
    .green(green), .blue(blue), .line_sync(line_sync),
    .frame_sync(frame_sync), .data_enable(data_enable), .spare(spare),
    .serial_lane_0(serial_lane_0), .serial_lane_1(serial_lane_1),
    .serial_lane_2(serial_lane_2), .serial_lane_3(serial_lane_3),
    .forwarded_clock_lane(forwarded_clock_lane),
    .lane_drive_en(lane_drive_en));

  pixel_source i_src (.run(run), .word_hi(word_hi), .word_lo(word_lo),
    .pixel_clock_in(pixel_clock_in), .red(red), .green(green), .blue(blue),
    .line_sync(line_sync), .frame_sync(frame_sync),
    .data_enable(data_enable), .spare(spare));

  // System clock, 25 ns period.
  always #12.5 clk = ~clk;

  function automatic logic [27:0] exp_frame(input logic [2:0] m,
                                            input logic [27:0] w);
    logic [27:0] d;
    logic [27:0] f;
    logic [7:0]  v;
    logic        b;
    d = '0;
    for (int c = 0; c < COLOURS; c++) begin
      v = w[c*8 +: 8];
      for (int k = 0; k < 8; k++) begin
        case (m)
          3'h1: b = v[(k + 2) % 8];
          3'h2: b = (k < 6) ? v[k + 2] : 1'b0;
          3'h3: b = (k < 6) ? v[k] : 1'b0;
          3'h4: b = (k < 2) ? v[k + 2] : ((k < 6) ? v[k - 2] : 1'b0);
          3'h5: b = (k == 0) ? 1'b1 : ((k > 1 && k < 6) ? v[k - 2] : 1'b0);
          default: b = v[k];
        endcase
        d[COLOUR_POS[c][k]] = b;
      end
    end
    d[D_HS] = w[W_HS];
    d[D_VS] = w[W_VS];
    d[D_DE] = w[W_DE];
    for (int l = 0; l < LANES; l++) begin
      for (int s = 0; s < SLOTS; s++) f[l*SLOTS+s] = d[LANE_BIT[l][s]];
    end
    return f;
  endfunction : exp_frame

  task automatic end_sim;
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Finds a frame start by the clock lane rising, then takes seven slots.
  task automatic grab(output logic [27:0] f);
    logic prev;
    int   n;
    prev = 1'b1;
    n = 0;
    @(negedge clk);
    while (!(forwarded_clock_lane === 1'b1 && prev === 1'b0) && n < 40) begin
      prev = forwarded_clock_lane;
      n++;
      @(negedge clk);
    end
    if (n >= 40) begin
      bad_count++;
      end_sim();
    end else begin
      for (int s = 0; s < SLOTS; s++) begin
        `CHK(forwarded_clock_lane, (s < 4) ? 1'b1 : 1'b0)
        `CHK(lane_drive_en, 1'b1)
        f[s] = serial_lane_0;
        f[SLOTS+s] = serial_lane_1;
        f[2*SLOTS+s] = serial_lane_2;
        f[3*SLOTS+s] = serial_lane_3;
        @(negedge clk);
      end
    end
  endtask : grab

  // Presents one word in a mode and judges a frame after the handoff.
  task automatic check_word(input logic [2:0] m, input logic [27:0] w,
                            input logic [27:0] e);
    logic [27:0] f;
    @(posedge clk);
    colour_mode <= m;
    word_hi <= w;
    word_lo <= w;
    repeat (60) @(posedge clk);
    grab(f);
    `CHK(f, e)
  endtask : check_word

  // Every format, plus an unused code that behaves as format 1.
  task automatic t_modes;
    for (int m = 0; m < 6; m++) begin
      check_word(m[2:0], 28'hD5A3C96,
                 exp_frame(m[2:0], 28'hD5A3C96));
    end
    check_word(3'h7, 28'h2A5C369, exp_frame(3'h0, 28'h2A5C369));
  endtask : t_modes

  // Different words in the two clock phases tell the capture edges apart.
  task automatic t_edge;
    logic [27:0] f;
    @(posedge clk);
    colour_mode <= 3'h0;
    word_hi <= 28'h1F0F0F0;
    word_lo <= 28'h60F0F0F;
    capture_edge_select <= 1'b1;
    repeat (60) @(posedge clk);
    grab(f);
    `CHK(f, exp_frame(3'h0, 28'h60F0F0F))
    @(posedge clk);
    capture_edge_select <= 1'b0;
    repeat (60) @(posedge clk);
    grab(f);
    `CHK(f, exp_frame(3'h0, 28'h1F0F0F0))
  endtask : t_edge

  // Shutdown with the pixel clock halted, then a cleared word on wake.
  task automatic t_power;
    logic [27:0] f;
    logic [5:0]  outs;
    run = 1'b0;
    repeat (10) @(posedge clk);
    power_down_n <= 1'b0;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      outs = {serial_lane_0, serial_lane_1, serial_lane_2, serial_lane_3,
              forwarded_clock_lane, lane_drive_en};
      `CHK(outs, 6'h00)
    end
    @(posedge clk);
    power_down_n <= 1'b1;
    repeat (20) @(posedge clk);
    grab(f);
    `CHK(f, 28'h0000000)
    run = 1'b1;
    check_word(3'h0, 28'h52C3A5A, exp_frame(3'h0, 28'h52C3A5A));
  endtask : t_power

  // Reset, scenarios, verdict.
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    capture_edge_select = 1'b1;
    power_down_n = 1'b1;
    colour_mode = 3'h0;
    run = 1'b1;
    word_hi = '0;
    word_lo = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_modes();
    t_edge();
    t_power();
    end_sim();
  end
endmodule : tb_parallel_pixel_to_serial_lane_mapper
